//--- core/fes_defines.svh
// Purpose: Offsets, field positions, reset values and counts for the front-end setup bank.
// Assumes: Avalon-MM byte addresses, one 32-bit word per register index.
// Notes: Register n sits at index FES_BASE_INDEX + n * FES_STRIDE; byte address is four times that.
`ifndef FES_DEFINES_SVH
`define FES_DEFINES_SVH
`define FES_ADDR_W      11
`define FES_BASE_INDEX  9'h0c2
`define FES_LAST_INDEX  9'h124
`define FES_STRIDE      9'h00e
`define FES_NUM_SETUPS  8
`define FES_RESET_VALUE 16'h0050
`define FES_WR_MASK     16'h0f7f
`define FES_GAIN_LSB    0
`define FES_BIPOLAR_BIT 4
`define FES_REF_LSB     5
`define FES_BUFP_LSB    8
`define FES_BUFM_LSB    10
`define FES_GAIN_MAXPOW 4'h7
`define FES_GAIN_HALF   4'h8
`define FES_GAIN_PRECH  4'h9
`define FES_BUF_RSVD    2'h3
`define FES_RESTART_CYC 4
`define FES_UNI_ZERO    24'h000000
`define FES_UNI_POS_FS  24'hffffff
`define FES_BIP_POS_FS  24'h7fffff
`define FES_BIP_NEG_FS  24'h800000
`endif

//--- core/fes_pkg.sv
// Purpose: Types shared by the front-end setup bank modules.
// Assumes: Field layout as given in fes_defines.svh.
// Notes: The setup struct packs the low twelve bits of a register, eleven live and reserved bit 7.
package fes_pkg;
   // Restart sequencer states, Gray along IDLE, HOLD, DONE.
   typedef enum logic [1:0] {
      FES_IDLE = 2'b00,
      FES_HOLD = 2'b01,
      FES_DONE = 2'b11
   } fes_state_t;
   // Reference source codes.
   typedef enum logic [1:0] {
      FES_REF_EXT1 = 2'b00,
      FES_REF_EXT2 = 2'b01,
      FES_REF_INT  = 2'b10,
      FES_REF_SUPP = 2'b11
   } fes_ref_t;
   // Live fields and reserved bit 7 of one setup register, most significant first.
   typedef struct packed {
      logic [1:0] buf_m;
      logic [1:0] buf_p;
      logic       rsvd;
      fes_ref_t   ref_sel;
      logic       bipolar;
      logic [3:0] gain;
   } fes_setup_t;
endpackage : fes_pkg

//--- core/fes_reg_if.sv
// Purpose: Carrier between the bus slave and the register bank.
// Assumes: One strobe per accepted access.
// Notes: The slave decodes the address; the bank only sees setup numbers.
`timescale 1ns/10ps
`default_nettype none
interface fes_reg_if;
   logic        wr_stb;  // Write commits this cycle.
   logic        rd_stb;  // Read data is captured this cycle.
   logic        hit;     // Address maps to a setup register.
   logic [2:0]  setup;   // Setup number addressed.
   logic [15:0] wdata;   // Write data, low half of the bus.
   logic [1:0]  lanes;   // Byte enables for the low two lanes.
   logic [15:0] rdata;   // Current value of the addressed register.
   modport slave (output wr_stb, rd_stb, hit, setup, wdata, lanes, input rdata);
   modport bank (input wr_stb, rd_stb, hit, setup, wdata, lanes, output rdata);
endinterface : fes_reg_if
`default_nettype wire

//--- core/fes_avmm_slave.sv
// Purpose: Avalon-MM slave front end for the setup bank.
// Assumes: Master holds a request until it samples waitrequest low.
// Notes: Every access completes in one wait cycle; unmapped reads return zero.
`timescale 1ns/10ps
`default_nettype none
`include "fes_defines.svh"
module fes_avmm_slave
   import fes_pkg::*;
(
   // Clock and reset.
   input  wire logic                   core_clk,
   input  wire logic                   rst_n,
   // Avalon-MM slave.
   input  wire logic [`FES_ADDR_W-1:0] avs_address,
   input  wire logic                   avs_read,
   input  wire logic                   avs_write,
   input  wire logic [31:0]            avs_writedata,
   input  wire logic [3:0]             avs_byteenable,
   output logic [31:0]                 avs_readdata,
   output logic                        avs_waitrequest,
   // Bank side.
   fes_reg_if.slave                    regs
);
   logic        ack_ff;       // High in the cycle the access completes.
   logic [31:0] readdata_ff;  // Captured read data.
   logic [8:0]  index;        // Word index of the access.

   // Finds which setup, if any, a word index addresses.
   function automatic logic [3:0] fes_decode(input logic [8:0] idx);
      logic [3:0] res;
      res = 4'h0;
      for (int n = 0; n < `FES_NUM_SETUPS; n++) begin
         if (idx == 9'(`FES_BASE_INDEX + n * `FES_STRIDE)) begin
            res = {1'b1, 3'(n)};
         end
      end
      return res;
   endfunction : fes_decode

   assign index = avs_address[`FES_ADDR_W-1:2];
   assign {regs.hit, regs.setup} = fes_decode(index);
   assign regs.wdata = avs_writedata[15:0];
   assign regs.lanes = avs_byteenable[1:0];
   // Writes commit on the edge the master sees waitrequest low.
   assign regs.wr_stb = avs_write & ack_ff;
   // Reads are captured one edge earlier so data stands at completion.
   assign regs.rd_stb = avs_read & ~ack_ff;
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
   assign avs_readdata = readdata_ff;

   // Raises the acknowledge for exactly one cycle per request.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= (avs_read | avs_write) & ~ack_ff;
      end
   end

   // Captures read data; unmapped words and upper bits read as zero.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         readdata_ff <= 32'h0000_0000;
      end else if (regs.rd_stb) begin
         readdata_ff <= regs.hit ? {16'h0000, regs.rdata} : 32'h0000_0000;
      end
   end

   a_wait_first: assert property (@(posedge core_clk) disable iff (!rst_n)
      (avs_read | avs_write) && !ack_ff |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("Slave did not answer after one wait cycle.");
   a_write_commit: assert property (@(posedge core_clk) disable iff (!rst_n)
      regs.wr_stb |-> !avs_waitrequest && $past(avs_write))
      else $error("Write committed outside the completing cycle.");
endmodule : fes_avmm_slave
`default_nettype wire

//--- core/fes_result_coder.sv
// Purpose: Encodes filter results as straight binary or two's complement.
// Assumes: Filter results arrive offset binary, 0x000000 at negative full scale.
// Notes: Unipolar passes the code through; bipolar inverts the sign bit.
`timescale 1ns/10ps
`default_nettype none
`include "fes_defines.svh"
module fes_result_coder
   import fes_pkg::*;
(
   // Clock and reset.
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   // Filter side.
   input  wire logic        raw_valid,
   input  wire logic [23:0] raw_code,
   input  wire logic        bipolar,
   // Result side.
   output logic             result_valid,
   output logic [23:0]      result_code
);
   logic        valid_ff;  // Result valid flag.
   logic [23:0] code_ff;   // Encoded result.

   assign result_valid = valid_ff;
   assign result_code  = code_ff;

   // Registers each result with the span of its setup.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         valid_ff <= 1'b0;
         code_ff  <= 24'h000000;
      end else begin
         valid_ff <= raw_valid;
         if (raw_valid) begin
            code_ff <= bipolar ? {~raw_code[23], raw_code[22:0]} : raw_code;
         end
      end
   end

   a_unipolar_fs: assert property (@(posedge core_clk) disable iff (!rst_n)
      raw_valid && !bipolar && raw_code == `FES_UNI_POS_FS |=> code_ff == `FES_UNI_POS_FS)
      else $error("Unipolar full scale not straight binary.");
   a_bipolar_span: assert property (@(posedge core_clk) disable iff (!rst_n)
      raw_valid && bipolar && (raw_code == `FES_UNI_POS_FS || raw_code == `FES_UNI_ZERO)
      |=> code_ff == (($past(raw_code) == `FES_UNI_ZERO) ? `FES_BIP_NEG_FS : `FES_BIP_POS_FS))
      else $error("Bipolar full scale not two's complement.");
   c_bipolar_result: cover property (@(posedge core_clk) disable iff (!rst_n) raw_valid && bipolar);
endmodule : fes_result_coder
`default_nettype wire

//--- core/fes_setup_bank.sv
// Purpose: Eight front-end setup registers with restart and per-setup decode.
// Assumes: Sequencer names the active setup; filter names each result's setup.
// Notes: Decode outputs lag the active setup by one cycle.
// Function
// - Eight 16-bit registers, fourteen apart from 0xC2.
// - Every register resets to 0x0050.
// - Each setup uses only its own register.
// - Any setup register write restarts filter, control and sequencer.
// - Two-bit field selects conversion reference source.
// - Unipolar span gives straight binary results.
// - Bipolar span gives two's complement results.
// - Gain codes 1..128, half, precharge; others reserved.
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "fes_defines.svh"
module fes_setup_bank
   import fes_pkg::*;
#(
   parameter int RESTART_CYCLES = `FES_RESTART_CYC  // Length of the restart pulse.
)(
   // Clock and reset.
   input  wire logic                   core_clk,
   input  wire logic                   rst_n,
   // Avalon-MM slave.
   input  wire logic [`FES_ADDR_W-1:0] avs_address,
   input  wire logic                   avs_read,
   input  wire logic                   avs_write,
   input  wire logic [31:0]            avs_writedata,
   input  wire logic [3:0]             avs_byteenable,
   output logic [31:0]                 avs_readdata,
   output logic                        avs_waitrequest,
   // Active setup and its decoded settings.
   input  wire logic [2:0]             active_setup,
   output logic [3:0]                  amplifier_gain_code,
   output logic [2:0]                  gain_shift,
   output logic                        gain_half,
   output logic                        gain_precharge,
   output fes_ref_t                    reference_select,
   output logic                        bipolar_span,
   output logic [1:0]                  ref_buf_pos,
   output logic [1:0]                  ref_buf_neg,
   output logic                        setup_code_reserved,
   // Restart of filter, control logic and sequencer.
   output logic                        pipeline_restart,
   // Filter results.
   input  wire logic                   raw_valid,
   input  wire logic [23:0]            raw_code,
   input  wire logic [2:0]             raw_setup,
   output logic                        result_valid,
   output logic [23:0]                 result_code
);
   fes_reg_if regs ();

   fes_setup_t  setup_ff [`FES_NUM_SETUPS];  // Register storage, one per setup.
   fes_setup_t  sel;                          // Register of the active setup.
   fes_state_t  state_ff;                     // Restart sequencer state.
   fes_state_t  nxt_state;                    // Next restart state.
   logic [7:0]  hold_cnt_ff;                  // Cycles left in the restart pulse.
   logic        restart_ff;                   // Registered restart output.
   logic [3:0]  gain_ff;                      // Gain code of the active setup.
   logic [2:0]  shift_ff;                     // Gain as a power of two.
   logic        half_ff;                      // Gain of one half.
   logic        prech_ff;                     // Unity gain with precharge.
   fes_ref_t    ref_ff;                       // Reference source.
   logic        bip_ff;                       // Span selection.
   logic [1:0]  bufp_ff;                      // Positive reference buffer mode.
   logic [1:0]  bufm_ff;                      // Negative reference buffer mode.
   logic        rsvd_ff;                      // A reserved code is in use.

   initial begin
      if (RESTART_CYCLES < 1 || RESTART_CYCLES > 255) begin
         $error("RESTART_CYCLES must lie in 1..255.");
      end
   end

   // True when the gain code is one of the defined settings.
   function automatic logic fes_gain_ok(input logic [3:0] code);
      return code <= `FES_GAIN_PRECH;
   endfunction : fes_gain_ok

   // True when a buffer code is one of the defined settings.
   function automatic logic fes_buf_ok(input logic [1:0] code);
      return code != `FES_BUF_RSVD;
   endfunction : fes_buf_ok

   // Merges byte lanes of a write into a register, dropping reserved bits.
   function automatic fes_setup_t fes_merge(input fes_setup_t old, input logic [15:0] wd,
                                            input logic [1:0] ln);
      logic [15:0] v;
      v = {4'h0, old};
      if (ln[0]) begin
         v[7:0] = wd[7:0];
      end
      if (ln[1]) begin
         v[15:8] = wd[15:8];
      end
      v = v & `FES_WR_MASK;
      return fes_setup_t'(v[11:0]);
   endfunction : fes_merge

   fes_avmm_slave u_slave (
      .core_clk        (core_clk),
      .rst_n           (rst_n),
      .avs_address     (avs_address),
      .avs_read        (avs_read),
      .avs_write       (avs_write),
      .avs_writedata   (avs_writedata),
      .avs_byteenable  (avs_byteenable),
      .avs_readdata    (avs_readdata),
      .avs_waitrequest (avs_waitrequest),
      .regs            (regs.slave)
   );

   // Read value of the addressed register; upper nibble reads zero.
   assign regs.rdata = {4'h0, setup_ff[regs.setup]};

   // Stores writes into the addressed setup register.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int n = 0; n < `FES_NUM_SETUPS; n++) begin
            setup_ff[n] <= fes_setup_t'(12'(`FES_RESET_VALUE));
         end
      end else if (regs.wr_stb && regs.hit) begin
         setup_ff[regs.setup] <= fes_merge(setup_ff[regs.setup], regs.wdata, regs.lanes);
      end
   end

   // Next state of the restart sequencer; a new write re-arms the pulse.
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         FES_IDLE: begin
            if (regs.wr_stb && regs.hit) begin
               nxt_state = FES_HOLD;
            end
         end
         FES_HOLD: begin
            if (!(regs.wr_stb && regs.hit) && hold_cnt_ff == 8'h01) begin
               nxt_state = FES_DONE;
            end
         end
         FES_DONE: begin
            nxt_state = (regs.wr_stb && regs.hit) ? FES_HOLD : FES_IDLE;
         end
         default: begin
            nxt_state = FES_IDLE;
         end
      endcase
   end

   // Advances the restart sequencer.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= FES_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Counts the restart pulse, reloading on every register write.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_cnt_ff <= 8'h00;
      end else if (regs.wr_stb && regs.hit) begin
         hold_cnt_ff <= 8'(RESTART_CYCLES);
      end else if (hold_cnt_ff != 8'h00) begin
         hold_cnt_ff <= hold_cnt_ff - 8'h01;
      end
   end

   // Drives the restart for as long as the sequencer holds.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         restart_ff <= 1'b0;
      end else begin
         restart_ff <= (nxt_state == FES_HOLD);
      end
   end

   assign pipeline_restart = restart_ff;
   assign sel = setup_ff[active_setup];

   // Registers the decoded settings of the active setup.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         gain_ff  <= 4'h0;
         shift_ff <= 3'h0;
         half_ff  <= 1'b0;
         prech_ff <= 1'b0;
         ref_ff   <= FES_REF_INT;
         bip_ff   <= 1'b1;
         bufp_ff  <= 2'h0;
         bufm_ff  <= 2'h0;
         rsvd_ff  <= 1'b0;
      end else begin
         gain_ff  <= sel.gain;
         shift_ff <= (sel.gain <= `FES_GAIN_MAXPOW) ? sel.gain[2:0] : 3'h0;
         half_ff  <= (sel.gain == `FES_GAIN_HALF);
         prech_ff <= (sel.gain == `FES_GAIN_PRECH);
         ref_ff   <= sel.ref_sel;
         bip_ff   <= sel.bipolar;
         bufp_ff  <= sel.buf_p;
         bufm_ff  <= sel.buf_m;
         rsvd_ff  <= !fes_gain_ok(sel.gain) || !fes_buf_ok(sel.buf_p) || !fes_buf_ok(sel.buf_m);
      end
   end

   assign amplifier_gain_code = gain_ff;
   assign gain_shift          = shift_ff;
   assign gain_half           = half_ff;
   assign gain_precharge      = prech_ff;
   assign reference_select    = ref_ff;
   assign bipolar_span        = bip_ff;
   assign ref_buf_pos         = bufp_ff;
   assign ref_buf_neg         = bufm_ff;
   assign setup_code_reserved = rsvd_ff;

   fes_result_coder u_coder (
      .core_clk     (core_clk),
      .rst_n        (rst_n),
      .raw_valid    (raw_valid),
      .raw_code     (raw_code),
      .bipolar      (setup_ff[raw_setup].bipolar),
      .result_valid (result_valid),
      .result_code  (result_code)
   );

   a_restart_write: assert property (@(posedge core_clk) disable iff (!rst_n)
      regs.wr_stb && regs.hit |=> pipeline_restart [*4])
      else $error("Register write did not hold restart for four cycles.");
   a_restart_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(pipeline_restart) |-> $past(regs.wr_stb && regs.hit))
      else $error("Restart rose without a register write.");
   a_store_full: assert property (@(posedge core_clk) disable iff (!rst_n)
      regs.wr_stb && regs.hit && regs.lanes == 2'h3
      |=> 16'({4'h0, setup_ff[$past(regs.setup)]}) == ($past(regs.wdata) & `FES_WR_MASK))
      else $error("Full write not stored with reserved bits cleared.");
   a_setup_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
      $stable(active_setup) && !regs.wr_stb
      |=> ref_ff == setup_ff[$past(active_setup)].ref_sel
          && gain_ff == setup_ff[$past(active_setup)].gain)
      else $error("Decoded settings do not follow the active setup.");
   a_reserved_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
      sel.gain > `FES_GAIN_PRECH |=> rsvd_ff)
      else $error("Reserved gain code not flagged.");
   a_reset_value: assert property (@(posedge core_clk)
      !rst_n |=> ref_ff == FES_REF_INT && bip_ff)
      else $error("Setup decode not at its reset value.");
   c_write_setup7: cover property (@(posedge core_clk) disable iff (!rst_n)
      regs.wr_stb && regs.hit && regs.setup == 3'h7);
   c_rearm: cover property (@(posedge core_clk) disable iff (!rst_n)
      pipeline_restart && regs.wr_stb && regs.hit);
   c_half_gain: cover property (@(posedge core_clk) disable iff (!rst_n) half_ff);
endmodule : fes_setup_bank
`default_nettype wire

//--- tb/fes_setup_bank_test.sv
// Purpose: Self-checking bench for the front-end setup bank over Avalon-MM.
// Assumes: One wait cycle per access; decode outputs lag one cycle.
// Notes: Restart length kept at its default of four cycles.
`timescale 1ns/10ps
`default_nettype none
`include "fes_defines.svh"
`define CHK(a, e) chk(32'(a), 32'(e))
module fes_setup_bank_test
   import fes_pkg::*;
;
   localparam int RC = 4;          // Restart pulse length under test.
   logic        core_clk;          // Core clock, 25 MHz.
   logic        rst_n;             // Active-low reset.
   logic [10:0] avs_address;       // Bus byte address.
   logic        avs_read;          // Bus read request.
   logic        avs_write;         // Bus write request.
   logic [31:0] avs_writedata;     // Bus write data.
   logic [3:0]  avs_byteenable;    // Bus byte lanes.
   logic [31:0] avs_readdata;      // Bus read data.
   logic        avs_waitrequest;   // Bus stall.
   logic [2:0]  active_setup;      // Setup in use.
   logic [3:0]  amplifier_gain_code;
   logic [2:0]  gain_shift;
   logic        gain_half;
   logic        gain_precharge;
   fes_ref_t    reference_select;
   logic        bipolar_span;
   logic [1:0]  ref_buf_pos;
   logic [1:0]  ref_buf_neg;
   logic        setup_code_reserved;
   logic        pipeline_restart;
   logic        raw_valid;         // Filter result strobe.
   logic [23:0] raw_code;          // Offset-binary filter result.
   logic [2:0]  raw_setup;         // Setup of the result.
   logic        result_valid;
   logic [23:0] result_code;
   int          n_fail;            // Mismatches.
   int          check_count;       // Comparisons.
   logic [15:0] q;                 // Read data scratch.
   int          k;                 // Loop and count scratch.

   fes_setup_bank #(.RESTART_CYCLES(RC)) u_fes_setup_bank (.core_clk(core_clk), .rst_n(rst_n),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .active_setup(active_setup),
      .amplifier_gain_code(amplifier_gain_code), .gain_shift(gain_shift), .gain_half(gain_half),
      .gain_precharge(gain_precharge), .reference_select(reference_select),
      .bipolar_span(bipolar_span), .ref_buf_pos(ref_buf_pos), .ref_buf_neg(ref_buf_neg),
      .setup_code_reserved(setup_code_reserved), .pipeline_restart(pipeline_restart),
      .raw_valid(raw_valid), .raw_code(raw_code), .raw_setup(raw_setup),
      .result_valid(result_valid), .result_code(result_code));

   // Clock generator, 40 ns period.
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   // Compares one value and counts the outcome.
   task automatic chk(input logic [31:0] a, input logic [31:0] e);
      check_count++;
      if (a !== e) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, a, e);
      end
   endtask : chk

   // Word index of setup register n.
   function automatic int idx(input int n);
      return 'hc2 + 14 * n;
   endfunction : idx

   // One Avalon-MM access, held until waitrequest is seen low.
   task automatic bus(input logic wr, input int i, input logic [15:0] d, input logic [3:0] be,
                      output logic [15:0] r);
      int w;
      @(posedge core_clk);
      avs_address    <= 11'(i * 4);
      avs_read       <= ~wr;
      avs_write      <= wr;
      avs_writedata  <= {16'h0000, d};
      avs_byteenable <= be;
      w = 0;
      do begin
         @(negedge core_clk);
         w++;
      end while (avs_waitrequest !== 1'b0 && w < 50);
      if (w >= 50) begin
         n_fail++;
         give_verdict();
      end
      @(posedge core_clk);
      r = avs_readdata[15:0];
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus

   // Register write with both low lanes by default.
   task automatic wr(input int i, input logic [15:0] d, input logic [3:0] be = 4'h3);
      logic [15:0] r;
      bus(1'b1, i, d, be, r);
   endtask : wr

   // Register read.
   task automatic rd(input int i, output logic [15:0] r);
      bus(1'b0, i, 16'h0000, 4'hf, r);
   endtask : rd

   // Selects the active setup and lets the decode settle.
   task automatic sel(input int n);
      @(posedge core_clk);
      active_setup <= 3'(n);
      repeat (2) @(negedge core_clk);
   endtask : sel

   // Counts restart cycles over a window after a bus access.
   task automatic cnt_restart(output int c);
      c = 0;
      repeat (RC + 2) begin
         @(negedge core_clk);
         if (pipeline_restart === 1'b1) c++;
      end
   endtask : cnt_restart

   // Sends one filter result; returns in the cycle of the answer.
   task automatic res(input int s, input logic [23:0] c);
      @(posedge core_clk);
      raw_valid <= 1'b1;
      raw_code  <= c;
      raw_setup <= 3'(s);
      @(posedge core_clk);
      raw_valid <= 1'b0;
      @(negedge core_clk);
   endtask : res

   // Prints counts and verdict, then ends the run.
   task automatic give_verdict();
      $display("checks=%0d mismatches=%0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : give_verdict

   // Watchdog against a hung handshake.
   initial begin
      repeat (20000) @(posedge core_clk);
      n_fail++;
      give_verdict();
   end

   // Main sequence.
   initial begin
      n_fail = 0; check_count = 0; rst_n = 1'b0; avs_address = '0; avs_read = 1'b0;
      avs_write = 1'b0; avs_writedata = '0; avs_byteenable = '0; active_setup = '0;
      raw_valid = 1'b0; raw_code = '0; raw_setup = '0;
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      // Reset contents and decode of setup 0.
      for (k = 0; k < 8; k++) begin
         rd(idx(k), q);
         `CHK(q, 16'h0050);
      end
      sel(0);
      `CHK({bipolar_span, reference_select, ref_buf_pos, ref_buf_neg, gain_shift}, 10'h300);
      // Unmapped place: reads zero, write causes no restart.
      rd('hc3, q);
      `CHK(q, 16'h0000);
      wr('hc3, 16'h0123);
      cnt_restart(k);
      `CHK(k, 0);
      // A full write to setup 7 restarts for the full count.
      wr(idx(7), 16'hffff);
      cnt_restart(k);
      `CHK(k, RC);
      rd(idx(7), q);
      `CHK(q, 16'h0f7f);
      // Byte lanes write independently.
      wr(idx(6), 16'h0a23, 4'h1);
      rd(idx(6), q);
      `CHK(q, 16'h0023);
      wr(idx(6), 16'h0b00, 4'h2);
      rd(idx(6), q);
      `CHK(q, 16'h0b23);
      // Distinct gain per setup; each setup shows only its own.
      for (k = 0; k < 8; k++) wr(idx(k), 16'(k) | 16'h0040);
      for (k = 7; k >= 0; k--) begin
         sel(k);
         `CHK(amplifier_gain_code, k);
         `CHK(bipolar_span, 0);
      end
      // Every gain code plus one reserved code.
      for (k = 0; k < 11; k++) begin
         wr(idx(5), 16'(k) | 16'h0050);
         sel(5);
         `CHK({gain_half, gain_precharge, setup_code_reserved, gain_shift},
              {k == 8, k == 9, k > 9, 3'(k < 8 ? k : 0)});
      end
      // Every reference and buffer code; software owns enabling the internal reference.
      for (k = 0; k < 4; k++) begin
         wr(idx(2), 16'(k * 'h500 + k * 'h20 + 'h10));
         sel(2);
         `CHK({reference_select, ref_buf_pos, ref_buf_neg, setup_code_reserved},
              {2'(k), 2'(k), 2'(k), k == 3});
      end
      // Result coding follows the result's own setup.
      sel(2);
      res(0, 24'hffffff);
      `CHK({result_valid, result_code}, 25'h1ffffff);
      res(0, 24'h000000);
      `CHK({result_valid, result_code}, 25'h1000000);
      res(2, 24'hffffff);
      `CHK({result_valid, result_code}, 25'h17fffff);
      res(2, 24'h000000);
      `CHK({result_valid, result_code}, 25'h1800000);
      give_verdict();
   end
endmodule : fes_setup_bank_test
`default_nettype wire
